// File: logic/sdcr_defs.svh
// Offsets, field positions, reset values and encodings of the socket DMA configuration registers
`ifndef SDCR_DEFS_SVH
`define SDCR_DEFS_SVH
`define SDCR_ADDR_W 8
`define SDCR_OFF_PIN_SEL 8'h94
`define SDCR_OFF_WINDOW 8'h98
`define SDCR_RST_PIN_SEL 32'h0000_0000
`define SDCR_RST_WINDOW 32'h0000_0000
`define SDCR_PIN_LSB 0
`define SDCR_PIN_MSB 1
`define SDCR_BASE_LSB 4
`define SDCR_BASE_MSB 15
`define SDCR_EXT_BIT 3
`define SDCR_WIDTH_LSB 1
`define SDCR_WIDTH_MSB 2
`define SDCR_EN_BIT 0
`define SDCR_PIN_NONE 2'h0
`define SDCR_PIN_SPKR 2'h1
`define SDCR_PIN_IOIS16 2'h2
`define SDCR_PIN_INPACK 2'h3
`define SDCR_WIDTH_8 2'h0
`define SDCR_WIDTH_16 2'h1
`endif

// File: logic/sdcr_pkg.sv
// Types shared by the socket DMA configuration registers
package sdcr_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic        valid;
  } sdcr_io_req_s;
  typedef struct packed {
    logic spkr;
    logic iois16;
    logic inpack;
  } sdcr_card_pins_s;
endpackage : sdcr_pkg

// File: logic/sdcr_regs.sv
// Socket DMA configuration registers with APB slave and window decode
//
// Contract
// R1: Pin-select register bits 31..2 read zero and ignore writes.
// R2: Card DMA request comes from SPKR, IOIS16 or INPACK per the pin field, 00 meaning no DMA.
// R3: Window register bits 31..16 read zero and are not writable.
// R4: Base field bits 15..4 give address bits 15..4 of the window.
// R5: Address bits 31..16 must be zero for a window hit, keeping it in the low 64K.
// R6: The window is 16-byte aligned, 16 bytes long, low four base bits fixed zero.
// R7: The extended-addressing bit 3 reads zero and ignores writes.
// R8: Width field 00 is 8-bit, 01 is 16-bit, 10 and 11 are reserved.
// R9: No card-side transfer is wider than 16 bits.
// R10: The decode-enable bit gates window decoding, off after reset.
// R11: A hit needs enable set, high address zero and bits 15..4 equal to the base.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sdcr_defs.svh"
module sdcr_regs (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire sdcr_pkg::sdcr_card_pins_s CARD_PINS,
  input wire sdcr_pkg::sdcr_io_req_s IO_REQ,
  output logic DMA_REQUEST,
  output logic WINDOW_HIT,
  output logic WIDTH_16,
  output logic WIDTH_RESERVED
);
  import sdcr_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [1:0] request_pin_select;
  logic [11:0] window_base_field;
  logic [1:0] transfer_width_field;
  logic window_decode_enable;
  logic [31:0] pin_reg_value;
  logic [31:0] window_reg_value;
  logic setup;
  logic hit_pin;
  logic hit_win;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_strb

  assign setup = PSEL && !PENABLE;
  assign hit_pin = (PADDR[`SDCR_ADDR_W-1:0] == `SDCR_OFF_PIN_SEL) && (PADDR[31:`SDCR_ADDR_W] == '0);
  assign hit_win = (PADDR[`SDCR_ADDR_W-1:0] == `SDCR_OFF_WINDOW) && (PADDR[31:`SDCR_ADDR_W] == '0);
  assign pin_reg_value = {30'h0, request_pin_select}; // R1
  assign window_reg_value = {16'h0, window_base_field, 1'b0, transfer_width_field, // R3 R7
                             window_decode_enable};

  // Ready one cycle after setup: access phase always completes in its first cycle
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !hit_pin && !hit_win;
      if (setup && !PWRITE) begin
        PRDATA <= hit_pin ? pin_reg_value : (hit_win ? window_reg_value : 32'h0);
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  logic wr_fire;
  logic [31:0] pin_new;
  logic [31:0] win_new;
  assign wr_fire = PSEL && PENABLE && PREADY && PWRITE;
  assign pin_new = merge_strb(pin_reg_value, PWDATA, PSTRB);
  assign win_new = merge_strb(window_reg_value, PWDATA, PSTRB);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      request_pin_select <= `SDCR_PIN_NONE;
    end else if (wr_fire && hit_pin) begin
      request_pin_select <= pin_new[`SDCR_PIN_MSB:`SDCR_PIN_LSB]; // R1
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      window_base_field <= 12'h0;
      transfer_width_field <= `SDCR_WIDTH_8;
      window_decode_enable <= 1'b0; // R10
    end else if (wr_fire && hit_win) begin
      window_base_field <= win_new[`SDCR_BASE_MSB:`SDCR_BASE_LSB]; // R4
      transfer_width_field <= win_new[`SDCR_WIDTH_MSB:`SDCR_WIDTH_LSB]; // R8
      window_decode_enable <= win_new[`SDCR_EN_BIT]; // R10
    end
  end

  // ----------------------------------------
  // Card request pin selection
  // ----------------------------------------
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {CARD_PINS.inpack, CARD_PINS.iois16, CARD_PINS.spkr};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      DMA_REQUEST <= 1'b0;
    end else begin
      case (request_pin_select) // R2
        `SDCR_PIN_SPKR: DMA_REQUEST <= pin_sync[0];
        `SDCR_PIN_IOIS16: DMA_REQUEST <= pin_sync[1];
        `SDCR_PIN_INPACK: DMA_REQUEST <= pin_sync[2];
        default: DMA_REQUEST <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Window decode and width
  // ----------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      WINDOW_HIT <= 1'b0;
      WIDTH_16 <= 1'b0;
      WIDTH_RESERVED <= 1'b0;
    end else begin
      WINDOW_HIT <= IO_REQ.valid && window_decode_enable // R10 R11
                    && (IO_REQ.addr[31:16] == 16'h0) // R5
                    && (IO_REQ.addr[15:4] == window_base_field); // R4 R6
      WIDTH_16 <= (transfer_width_field == `SDCR_WIDTH_16); // R8 R9
      WIDTH_RESERVED <= transfer_width_field[1]; // R8
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_win_write;
    PSEL && PENABLE && PREADY && PWRITE && hit_win && (PSTRB == 4'hf);
  endsequence

  sequence s_pin_write;
    PSEL && PENABLE && PREADY && PWRITE && hit_pin && PSTRB[0];
  endsequence

  AST_PIN_UPPER_ZERO: assert property (@(posedge CLK) disable iff (!rst_n) // R1
    PREADY && !PWRITE && $past(hit_pin) |-> PRDATA[31:2] == 30'h0)
    else $error("Pin register upper bits not zero");
  AST_WIN_UPPER_ZERO: assert property (@(posedge CLK) disable iff (!rst_n) // R3
    PREADY && !PWRITE && $past(hit_win) |-> PRDATA[31:16] == 16'h0)
    else $error("Window register upper bits not zero");
  AST_EXT_ZERO: assert property (@(posedge CLK) disable iff (!rst_n) // R7
    PREADY && !PWRITE && $past(hit_win) |-> PRDATA[3] == 1'b0)
    else $error("Extended addressing bit read one");
  AST_PIN_SELECT: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    request_pin_select == `SDCR_PIN_NONE |=> !DMA_REQUEST)
    else $error("Request seen with DMA off");
  AST_BASE_WRITE: assert property (@(posedge CLK) disable iff (!rst_n) // R4
    s_win_write |=> window_base_field == $past(PWDATA[15:4]))
    else $error("Base field not written");
  AST_HIGH_ADDR: assert property (@(posedge CLK) disable iff (!rst_n) // R5
    IO_REQ.addr[31:16] != 16'h0 |=> !WINDOW_HIT)
    else $error("Hit above 64K");
  AST_LOW_NIBBLE: assert property (@(posedge CLK) disable iff (!rst_n) // R6
    IO_REQ.valid && window_decode_enable && IO_REQ.addr[31:4] == {16'h0, window_base_field}
    |=> WINDOW_HIT)
    else $error("Aligned window access missed");
  AST_WIDTH: assert property (@(posedge CLK) disable iff (!rst_n) // R8
    s_win_write ##1 1'b1 |=> WIDTH_16 == ($past(PWDATA[2:1], 2) == `SDCR_WIDTH_16))
    else $error("Width output mismatch");
  AST_NO_WIDE: assert property (@(posedge CLK) disable iff (!rst_n) // R9
    !(WIDTH_16 && WIDTH_RESERVED))
    else $error("Wider than 16 bits");
  AST_DISABLED: assert property (@(posedge CLK) disable iff (!rst_n) // R10
    !window_decode_enable |=> !WINDOW_HIT)
    else $error("Hit while disabled");
  AST_HIT_CAUSE: assert property (@(posedge CLK) disable iff (!rst_n) // R11
    WINDOW_HIT |-> $past(IO_REQ.valid) && $past(IO_REQ.addr[15:4]) == $past(window_base_field))
    else $error("Hit without matching base");
  AST_PIN_WRITE: assert property (@(posedge CLK) disable iff (!rst_n) // R1
    s_pin_write |=> request_pin_select == $past(PWDATA[1:0]))
    else $error("Pin field not written");
  AST_PIN_SPKR: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    request_pin_select == `SDCR_PIN_SPKR |=> DMA_REQUEST == $past(pin_sync[0]))
    else $error("Request not taken from first pin");
  AST_PIN_IOIS16: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    request_pin_select == `SDCR_PIN_IOIS16 |=> DMA_REQUEST == $past(pin_sync[1]))
    else $error("Request not taken from second pin");
  AST_PIN_INPACK: assert property (@(posedge CLK) disable iff (!rst_n) // R2
    request_pin_select == `SDCR_PIN_INPACK |=> DMA_REQUEST == $past(pin_sync[2]))
    else $error("Request not taken from third pin");
  AST_BASE_READ: assert property (@(posedge CLK) disable iff (!rst_n) // R4
    PREADY && !PWRITE && $past(hit_win) |-> PRDATA[15:4] == window_base_field)
    else $error("Base field read back wrong");
  AST_EN_WRITE: assert property (@(posedge CLK) disable iff (!rst_n) // R10
    s_win_write |=> window_decode_enable == $past(PWDATA[0]))
    else $error("Decode enable not written");
  AST_WIDTH_RSV: assert property (@(posedge CLK) disable iff (!rst_n) // R8
    s_win_write ##1 1'b1 |=> WIDTH_RESERVED == $past(PWDATA[2], 2))
    else $error("Reserved width flag mismatch");
  AST_HIT_LOW: assert property (@(posedge CLK) disable iff (!rst_n) // R11
    WINDOW_HIT |-> $past(IO_REQ.addr[31:16]) == 16'h0 && $past(window_decode_enable))
    else $error("Hit outside low space or while disabled");
endmodule : sdcr_regs

// File: test/sdcr_card_model.sv
// Card-side model that signals its DMA request on the chosen pin
`timescale 1ns/1ps
module sdcr_card_model (
  input wire logic clk,
  input wire logic [1:0] pin,
  input wire logic req,
  output sdcr_pkg::sdcr_card_pins_s card_pins
);
  import sdcr_pkg::*;
  // Pins not carrying the request show its inverse
  always_ff @(posedge clk) begin
    card_pins.spkr <= (pin == 2'h1) ? req : ~req;
    card_pins.iois16 <= (pin == 2'h2) ? req : ~req;
    card_pins.inpack <= (pin == 2'h3) ? req : ~req;
  end
endmodule : sdcr_card_model

// File: test/testbench.sv
// Self-checking bench for the socket DMA configuration registers
`timescale 1ns/1ps
`include "sdcr_defs.svh"
module testbench;
  import sdcr_pkg::*;
  logic CLK, ARST_N, psel, penable, pwrite, e, req;
  logic [31:0] paddr, pwdata, q, PRDATA, rnd, pin_m, win_m, d;
  logic PREADY, PSLVERR, DMA_REQUEST, WINDOW_HIT, WIDTH_16, WIDTH_RESERVED;
  sdcr_io_req_s io;
  sdcr_card_pins_s pins;
  int fail_count, check_count;
  sdcr_regs sdcr_regs_inst (.CLK(CLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CARD_PINS(pins), .IO_REQ(io),
    .DMA_REQUEST(DMA_REQUEST), .WINDOW_HIT(WINDOW_HIT), .WIDTH_16(WIDTH_16),
    .WIDTH_RESERVED(WIDTH_RESERVED));
  sdcr_card_model sdcr_card_model_inst (.clk(CLK), .pin(pin_m[1:0]), .req(req),
    .card_pins(pins));
  initial begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
    @(posedge CLK);
    penable <= 1;
    n = 0;
    do begin @(posedge CLK); n++; end while (PREADY !== 1'b1 && n < 50);
    chk(n < 50, "no ready");
    if (n >= 50) print_verdict();
    q = PRDATA;
    e = PSLVERR;
    psel <= 0; penable <= 0;
    if (w && a == 32'h94) pin_m <= wd & 32'h3;
    if (w && a == 32'h98) win_m <= wd & 32'hfff7;
    @(posedge CLK);
  endtask : acc
  task automatic dec(input logic [31:0] a);
    @(posedge CLK);
    io <= '{addr: a, valid: 1'b1};
    @(posedge CLK);
    @(negedge CLK);
    chk(WINDOW_HIT === (win_m[0] && a[31:16] == 0 && a[15:4] == win_m[15:4]), "hit");
  endtask : dec
  initial begin
    ARST_N = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; req = 0;
    io = '0; rnd = 1; pin_m = 0; win_m = 0; fail_count = 0; check_count = 0;
    repeat (12) @(posedge CLK);
    ARST_N <= 1;
    repeat (4) @(posedge CLK);
    acc(0, {24'h0, `SDCR_OFF_PIN_SEL}, 0);
    chk(q === `SDCR_RST_PIN_SEL, "pin reset");
    acc(0, {24'h0, `SDCR_OFF_WINDOW}, 0);
    chk(q === `SDCR_RST_WINDOW && WIDTH_16 === 1'b0, "window reset");
    dec(32'h0);
    acc(1, 32'h9c, 32'hffffffff);
    chk(e === 1'b1, "unmapped write");
    acc(0, 32'h9c, 0);
    chk(e === 1'b1 && q === 32'h0, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      acc(1, 32'h94, {rnd[31:2], i[1:0]});
      acc(0, 32'h94, 0);
      chk(q === pin_m && e === 1'b0, "pin field");
      req <= rnd[5];
      repeat (5) @(posedge CLK);
      @(negedge CLK);
      chk(DMA_REQUEST === (pin_m != 0 && rnd[5]), "request pin");
      d = {rnd[31:3], i[1:0], ~rnd[7] | (i < 2)};
      acc(1, 32'h98, d);
      acc(0, 32'h98, 0);
      chk(q === win_m, "window reg");
      @(negedge CLK);
      chk(WIDTH_16 === (i == 1) && WIDTH_RESERVED === (i > 1), "width");
      dec({16'h0, d[15:4], rnd[9:6]});
      dec({16'h0, d[15:4], 4'hf});
      dec({rnd[31:17], 1'b1, d[15:4], 4'h0});
      dec({16'h0, d[15:4] ^ (12'h1 << (i * 3)), 4'h0});
    end
    io <= '0;
    print_verdict();
  end
endmodule : testbench
